//--- src/rcvd_top.sv
// Reset cause recorder and supply voltage detector control.
// Assumes a 20 MHz clock, a power-on reset on rst_b_i, and comparator
// outcomes from an analog monitor that are asynchronous to clk_i.
//
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "rcvd_regs.svh"
module rcvd_top (
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       detector_mode_option_hi_i,
  input  wire logic       detector_mode_option_lo_i,
  input  wire logic       vdd_below_level_i,
  input  wire logic       vdd_below_lower_i,
  input  wire logic       wdog_rst_req_i,
  input  wire logic       illins_rst_req_i,
  input  wire logic       illmem_rst_req_i,
  input  wire logic       clkmon_rst_req_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  output logic            int_rst_b_o,
  output logic            lvd_irq_o,
  output logic            irq_o
);
  import rcvd_pkg::*;

  localparam int STAB_CYC = `RCVD_STAB_CYC;
  localparam logic [15:0] STAB_LAST = 16'(STAB_CYC - 1);

  logic [1:0]  cmp_sync;
  logic        below_lvl;
  logic        below_low;
  logic        below_lvl_d;
  rcvd_state_t state_reg;
  logic [15:0] stab_cnt_reg;
  logic [4:0]  cause_reg;
  logic        por_stat_reg;
  logic [7:0]  level_reg;
  logic [7:0]  level_def;
  logic [2:0]  level_max;
  logic        det_en_reg;
  rcvd_mode_t  mode;
  logic        lvd_rst_reg;
  logic        src_rst;
  logic        lvd_rst_next;
  logic        fall_evt;
  logic        rise_evt;
  logic [1:0]  irq_stat_reg;
  logic [1:0]  irq_mask_reg;
  logic        rd_cause;
  logic        rd_stat;
  logic        in_reset;

  // Comparator outcomes cross into clk_i domain; only supply monitored
  rcvd_sync #(.W(2)) u_sync (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .async_i ({vdd_below_lower_i, vdd_below_level_i}),
    .sync_o  (cmp_sync)
  );
  assign below_lvl = cmp_sync[0];
  assign below_low = cmp_sync[1];

  // Mode from the option bits
  assign mode = rcvd_mode_t'({detector_mode_option_hi_i, detector_mode_option_lo_i});

  always_comb begin
    case (mode)
      RCVD_MODE_RST:     level_def = `RCVD_LVL_DEF_10;
      RCVD_MODE_IRQ_RST: level_def = `RCVD_LVL_DEF_11;
      RCVD_MODE_IRQ:     level_def = `RCVD_LVL_DEF_01;
      default:           level_def = `RCVD_LVL_DEF_10;
    endcase
  end

  assign level_max = (mode == RCVD_MODE_IRQ_RST) ? `RCVD_LEVELS_PAIR : `RCVD_LEVELS_SINGLE;

  // Power-up sequence: settle wait, then run
  // stabilisation hold
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      state_reg    <= RCVD_ST_POR;
      stab_cnt_reg <= 16'h0000;
    end else begin
      case (state_reg)
        RCVD_ST_POR: begin
          state_reg    <= RCVD_ST_STAB;
          stab_cnt_reg <= 16'h0000;
        end
        RCVD_ST_STAB: begin
          if (stab_cnt_reg == STAB_LAST) begin
            state_reg <= RCVD_ST_RUN;
          end else begin
            stab_cnt_reg <= stab_cnt_reg + 16'h0001;
          end
        end
        RCVD_ST_RUN: state_reg <= RCVD_ST_RUN;
        default:     state_reg <= RCVD_ST_POR;
      endcase
    end
  end

  // Detector reset request per mode
  always_comb begin
    lvd_rst_next = 1'b0;
    case (mode)
      // reset below lower, released only back at upper level
      RCVD_MODE_IRQ_RST: lvd_rst_next = below_low | (lvd_rst_reg & below_lvl);
      RCVD_MODE_RST:     lvd_rst_next = below_lvl;
      // power-on hold until level is first reached
      RCVD_MODE_IRQ:     lvd_rst_next = ~det_en_reg & below_lvl;
      default:           lvd_rst_next = 1'b0;
    endcase
  end

  // Detector reset state and first-reach latch; survives its own reset
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      lvd_rst_reg <= 1'b1;
      det_en_reg  <= 1'b0;
    end else begin
      lvd_rst_reg <= lvd_rst_next;
      if (!below_lvl && state_reg == RCVD_ST_RUN) begin
        det_en_reg <= 1'b1;
      end
    end
  end

  assign src_rst  = wdog_rst_req_i | illins_rst_req_i | illmem_rst_req_i | clkmon_rst_req_i;
  assign in_reset = (state_reg != RCVD_ST_RUN) | lvd_rst_reg | src_rst;

  // Internal reset output, registered
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      int_rst_b_o <= 1'b0;
    end else begin
      int_rst_b_o <= ~in_reset;
    end
  end

  // Level register: software writes, default on non-detector resets
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      level_reg <= 8'h00;
    end else if (state_reg == RCVD_ST_POR || (src_rst && !lvd_rst_reg)) begin
      level_reg <= level_def;
    end else if (wr_i && addr_i == `RCVD_OFS_LEVEL) begin
      if (wdata_i[2:0] < level_max) begin
        level_reg <= wdata_i;
      end else begin
        level_reg <= {wdata_i[7:3], level_max - 3'd1};
      end
    end
  end

  assign rd_cause = rd_i && addr_i == `RCVD_OFS_CAUSE;
  assign rd_stat  = rd_i && addr_i == `RCVD_OFS_IRQ_STAT;

  // Cause flags: set wins over the read clear
  // per-source sticky flags
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      cause_reg    <= 5'h00;
      por_stat_reg <= 1'b0;
    end else begin
      cause_reg <= (rd_cause ? 5'h00 : cause_reg)
                 | {lvd_rst_next & ~lvd_rst_reg & (state_reg == RCVD_ST_RUN),
                    clkmon_rst_req_i, illmem_rst_req_i, illins_rst_req_i, wdog_rst_req_i};
      if (state_reg == RCVD_ST_STAB) begin
        por_stat_reg <= 1'b1;
      end
    end
  end

  // Edge events for the detector interrupt
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      below_lvl_d <= 1'b0;
    end else begin
      below_lvl_d <= below_lvl;
    end
  end
  assign fall_evt = below_lvl & ~below_lvl_d & (state_reg == RCVD_ST_RUN);
  assign rise_evt = ~below_lvl & below_lvl_d & (state_reg == RCVD_ST_RUN);

  // Detector interrupt pulse and sticky status; set beats read clear
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      lvd_irq_o    <= 1'b0;
      irq_stat_reg <= 2'b00;
    end else begin
      // falling in both interrupt modes (not reset-only or off), rising only in interrupt-only mode
      lvd_irq_o <= (mode[0] & fall_evt) | ((mode == RCVD_MODE_IRQ) & rise_evt);
      irq_stat_reg <= (rd_stat ? 2'b00 : irq_stat_reg)
                    | {(mode == RCVD_MODE_IRQ) & rise_evt, mode[0] & fall_evt};
    end
  end

  // Mask register and level interrupt output
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      irq_mask_reg <= 2'b00;
      irq_o        <= 1'b0;
    end else begin
      if (wr_i && addr_i == `RCVD_OFS_IRQ_MASK) begin
        irq_mask_reg <= wdata_i[1:0];
      end
      irq_o <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // Read data stands one cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        `RCVD_OFS_CAUSE:    rdata_o <= {3'b000, cause_reg};
        `RCVD_OFS_PORSTAT:  rdata_o <= {7'h00, por_stat_reg};
        `RCVD_OFS_MODE:     rdata_o <= {4'h0, below_lvl, lvd_rst_reg, mode};
        `RCVD_OFS_LEVEL:    rdata_o <= level_reg;
        `RCVD_OFS_IRQ_STAT: rdata_o <= {6'h00, irq_stat_reg};
        `RCVD_OFS_IRQ_MASK: rdata_o <= {6'h00, irq_mask_reg};
        default:            rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // reset stays asserted while the sequence is not yet in run
  stab_hold_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (state_reg != RCVD_ST_RUN) |=> !int_rst_b_o)
    else $error("reset released before stabilisation");
  cause_clear_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (rd_cause && !src_rst && !(lvd_rst_next && !lvd_rst_reg)) |=> cause_reg == 5'h00)
    else $error("cause flags not cleared by read");
  cause_read_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    rd_cause |=> rdata_o == {3'b000, $past(cause_reg)})
    else $error("cause read data wrong");
  wdog_flag_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    wdog_rst_req_i |=> cause_reg[`RCVD_BIT_WDOG])
    else $error("watchdog flag not set");
  clkmon_flag_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    clkmon_rst_req_i |=> cause_reg[`RCVD_BIT_CLKMON])
    else $error("clock monitor flag not set");
  rst_mode_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (mode == RCVD_MODE_RST && below_lvl) |=> ##1 !int_rst_b_o)
    else $error("reset-only mode failed to assert reset");
  pair_low_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (mode == RCVD_MODE_IRQ_RST && below_low) |=> lvd_rst_reg)
    else $error("lower level did not reset");
  pair_hold_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (mode == RCVD_MODE_IRQ_RST && lvd_rst_reg && below_lvl) |=> lvd_rst_reg)
    else $error("reset released below upper level");
  pair_fall_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (mode == RCVD_MODE_IRQ_RST && fall_evt) |=> lvd_irq_o)
    else $error("fall interrupt missing");
  rise_irq_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (mode == RCVD_MODE_IRQ && rise_evt) |=> lvd_irq_o)
    else $error("rise interrupt missing");
  irq_por_hold_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (mode == RCVD_MODE_IRQ && !det_en_reg && below_lvl) |=> lvd_rst_reg)
    else $error("interrupt mode released reset below level");
  level_max_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (wr_i && addr_i == `RCVD_OFS_LEVEL && state_reg == RCVD_ST_RUN && !src_rst)
      |=> level_reg[2:0] < level_max)
    else $error("level index out of range");
  level_def_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (src_rst && !lvd_rst_reg) |=> level_reg == $past(level_def))
    else $error("level default not loaded");
  por_def_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (state_reg == RCVD_ST_POR) |=> level_reg == $past(level_def))
    else $error("power-up level default not loaded");
endmodule : rcvd_top
`default_nettype wire

//--- include/rcvd_regs.svh
// Register offsets, field positions, reset values and timing counts
// for the reset cause and voltage detect block.
// Assumes a 20 MHz system clock and an 8-bit register port.
`ifndef RCVD_REGS_SVH
`define RCVD_REGS_SVH

// Register offsets (byte address on the plain port)
`define RCVD_OFS_CAUSE      8'h00
`define RCVD_OFS_PORSTAT    8'h01
`define RCVD_OFS_MODE       8'h02
`define RCVD_OFS_LEVEL      8'h03
`define RCVD_OFS_IRQ_STAT   8'h04
`define RCVD_OFS_IRQ_MASK   8'h05

// Cause flag bit positions
`define RCVD_BIT_WDOG       0
`define RCVD_BIT_ILLINS     1
`define RCVD_BIT_ILLMEM     2
`define RCVD_BIT_CLKMON     3
`define RCVD_BIT_LVD        4

// Level register defaults by option pattern {hi,lo}
`define RCVD_LVL_DEF_10     8'h00
`define RCVD_LVL_DEF_11     8'h81
`define RCVD_LVL_DEF_01     8'h01

// Level selector limits
`define RCVD_LEVELS_SINGLE  3'd6
`define RCVD_LEVELS_PAIR    3'd4

// Stabilisation wait: 0.99 ms typical, at 20 MHz
`define RCVD_STAB_NS        990000
`define RCVD_CLK_NS         50
`define RCVD_STAB_CYC       (`RCVD_STAB_NS / `RCVD_CLK_NS)

`endif

//--- include/rcvd_pkg.sv
// Types shared by the reset cause and voltage detect block.
// Assumes nothing beyond the register header.
package rcvd_pkg;
  // Detector modes, decoded from the two option bits
  typedef enum logic [1:0] {
    RCVD_MODE_OFF     = 2'b00,
    RCVD_MODE_IRQ     = 2'b01,
    RCVD_MODE_RST     = 2'b10,
    RCVD_MODE_IRQ_RST = 2'b11
  } rcvd_mode_t;

  // Power-up sequence states, Gray coded along the path
  typedef enum logic [1:0] {
    RCVD_ST_POR  = 2'b00,
    RCVD_ST_STAB = 2'b01,
    RCVD_ST_RUN  = 2'b11
  } rcvd_state_t;
endpackage : rcvd_pkg

//--- src/rcvd_sync.sv
// Two-flop synchroniser for a bundle of asynchronous levels.
// Assumes one clock; inputs come from the supply monitor.
`timescale 1ns/1ps
`default_nettype none
module rcvd_sync #(
  parameter int W = 2
) (
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] meta_reg;

  // First flop feeds only the second one
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      meta_reg <= '0;
      sync_o   <= '0;
    end else begin
      meta_reg <= async_i;
      sync_o   <= meta_reg;
    end
  end
endmodule : rcvd_sync
`default_nettype wire

//--- verification/rcvd_top_tb.sv
// Self-checking bench for the reset cause and voltage detect block.
// Assumes the register header and one 20 MHz clock; no partner model.
`timescale 1ns/1ps
`default_nettype none
`include "rcvd_regs.svh"
module rcvd_top_tb;
  import rcvd_pkg::*;
  logic       clk_i = 1'b0;
  logic       rst_b_i = 1'b0;
  logic       opt_hi = 1'b1;
  logic       opt_lo = 1'b0;
  logic       below_lvl = 1'b0;
  logic       below_low = 1'b0;
  logic [3:0] src_req = 4'h0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic       wr_i = 1'b0;
  logic       rd_i = 1'b0;
  logic [7:0] rdata_o;
  logic       int_rst_b_o;
  logic       lvd_irq_o;
  logic       irq_o;
  int         n_fail = 0;
  int         p0 = 0;
  int         check_count = 0;
  int         n_pulse = 0;

  rcvd_top u_rcvd_top (
    .clk_i                     (clk_i),
    .rst_b_i                   (rst_b_i),
    .detector_mode_option_hi_i (opt_hi),
    .detector_mode_option_lo_i (opt_lo),
    .vdd_below_level_i         (below_lvl),
    .vdd_below_lower_i         (below_low),
    .wdog_rst_req_i            (src_req[0]),
    .illins_rst_req_i          (src_req[1]),
    .illmem_rst_req_i          (src_req[2]),
    .clkmon_rst_req_i          (src_req[3]),
    .addr_i                    (addr_i),
    .wdata_i                   (wdata_i),
    .wr_i                      (wr_i),
    .rd_i                      (rd_i),
    .rdata_o                   (rdata_o),
    .int_rst_b_o               (int_rst_b_o),
    .lvd_irq_o                 (lvd_irq_o),
    .irq_o                     (irq_o)
  );

  // 50 ns period clock
  always #25 clk_i = ~clk_i;

  // Count detector interrupt pulses; the output is registered, so edge sampling is safe
  always @(posedge clk_i) begin
    if (lvd_irq_o === 1'b1) n_pulse <= n_pulse + 1;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Read data stand only in the cycle after the strobe, so sample mid-cycle there
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    @(negedge clk_i);
    chk(rdata_o, exp);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= v;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask : wr

  // Bounded wait for internal reset release, sampled mid-cycle; count must lie in [lo,hi]
  task automatic wait_rel(input int lo, input int hi);
    int n;
    n = 0;
    while (int_rst_b_o !== 1'b1 && n <= hi) begin
      @(negedge clk_i);
      n++;
    end
    chk(8'((n >= lo) && (n <= hi)), 8'h01);
  endtask : wait_rel

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc

  // Power-up with the given option bits and supply state, then check the level default
  task automatic por(input logic hi, input logic lo, input logic [7:0] def, input logic low);
    @(posedge clk_i);
    rst_b_i   <= 1'b0;
    opt_hi    <= hi;
    opt_lo    <= lo;
    below_lvl <= low;
    cyc(6);
    rst_b_i <= 1'b1;
    if (low) begin
      // Supply still low: reset must hold past the settle wait until the level is reached
      cyc(`RCVD_STAB_CYC + 20);
      chk(8'(int_rst_b_o), 8'h00);
      below_lvl <= 1'b0;
      wait_rel(0, 10);
    end else begin
      wait_rel(`RCVD_STAB_CYC, `RCVD_STAB_CYC + 12);
    end
    rd(`RCVD_OFS_LEVEL, def);
    rd(`RCVD_OFS_PORSTAT, 8'h01);
    $display("power-up test done, options %b%b", hi, lo);
  endtask : por

  task automatic results();
    $display("checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results

  // Watchdog: four power-ups of about 19800 cycles each plus short tests
  initial begin
    #(90000 * 50);
    n_fail++;
    results();
  end

  initial begin
    por(1'b1, 1'b0, `RCVD_LVL_DEF_10, 1'b0);
    rd(`RCVD_OFS_MODE, 8'h02);
    rd(`RCVD_OFS_CAUSE, 8'h00);
    wr(`RCVD_OFS_LEVEL, 8'h07);
    rd(`RCVD_OFS_LEVEL, 8'h05);
    // Each source sets its own flag, defaults the level, and a read clears the flags
    for (int i = 0; i < 4; i++) begin
      wr(`RCVD_OFS_LEVEL, 8'h03);
      @(posedge clk_i);
      src_req <= 4'(1 << i);
      @(posedge clk_i);
      src_req <= 4'h0;
      cyc(4);
      wait_rel(0, 200);
      rd(`RCVD_OFS_CAUSE, 8'(1 << i));
      rd(`RCVD_OFS_CAUSE, 8'h00);
      rd(`RCVD_OFS_LEVEL, `RCVD_LVL_DEF_10);
    end
    $display("reset source test done");
    // Reset-only mode: detector reset keeps the level register
    wr(`RCVD_OFS_LEVEL, 8'h02);
    @(posedge clk_i);
    below_lvl <= 1'b1;
    cyc(8);
    chk(8'(int_rst_b_o), 8'h00);
    chk(8'(n_pulse), 8'h00);
    below_lvl <= 1'b0;
    wait_rel(0, 10);
    rd(`RCVD_OFS_CAUSE, 8'h10);
    rd(`RCVD_OFS_LEVEL, 8'h02);
    $display("reset-only test done");

    por(1'b1, 1'b1, `RCVD_LVL_DEF_11, 1'b0);
    wr(`RCVD_OFS_IRQ_MASK, 8'h03);
    wr(`RCVD_OFS_LEVEL, 8'h07);
    rd(`RCVD_OFS_LEVEL, 8'h03);
    p0 = n_pulse;
    @(posedge clk_i);
    below_lvl <= 1'b1;
    cyc(8);
    chk(8'(n_pulse - p0), 8'h01);
    chk(8'(int_rst_b_o), 8'h01);
    chk(8'(irq_o), 8'h01);
    below_low <= 1'b1;
    cyc(8);
    chk(8'(int_rst_b_o), 8'h00);
    below_low <= 1'b0;
    cyc(8);
    chk(8'(int_rst_b_o), 8'h00);
    below_lvl <= 1'b0;
    wait_rel(0, 10);
    rd(`RCVD_OFS_CAUSE, 8'h10);
    rd(`RCVD_OFS_IRQ_STAT, 8'h01);
    rd(`RCVD_OFS_IRQ_STAT, 8'h00);
    cyc(2);
    chk(8'(irq_o), 8'h00);
    $display("interrupt-and-reset test done");

    por(1'b0, 1'b1, `RCVD_LVL_DEF_01, 1'b1);
    wr(`RCVD_OFS_IRQ_MASK, 8'h00);
    wr(`RCVD_OFS_LEVEL, 8'h06);
    rd(`RCVD_OFS_LEVEL, 8'h05);
    wr(8'h3c, 8'hff);
    rd(8'h3c, 8'h00);
    p0 = n_pulse;
    @(posedge clk_i);
    below_lvl <= 1'b1;
    cyc(8);
    chk(8'(irq_o), 8'h00);
    chk(8'(int_rst_b_o), 8'h01);
    wr(`RCVD_OFS_IRQ_MASK, 8'h02);
    below_lvl <= 1'b0;
    cyc(8);
    chk(8'(n_pulse - p0), 8'h02);
    chk(8'(irq_o), 8'h01);
    rd(`RCVD_OFS_IRQ_STAT, 8'h03);
    cyc(2);
    chk(8'(irq_o), 8'h00);
    rd(`RCVD_OFS_CAUSE, 8'h00);
    $display("interrupt-only test done");

    // Detector off: a low supply neither resets nor interrupts
    por(1'b0, 1'b0, `RCVD_LVL_DEF_10, 1'b0);
    p0 = n_pulse;
    @(posedge clk_i);
    below_lvl <= 1'b1;
    cyc(8);
    chk(8'(int_rst_b_o), 8'h01);
    chk(8'(n_pulse - p0), 8'h00);
    rd(`RCVD_OFS_MODE, 8'h08);
    @(posedge clk_i);
    below_lvl <= 1'b0;
    $display("detector-off test done");
    results();
  end
endmodule : rcvd_top_tb
`default_nettype wire
